// ===== core/urxb_pkg.sv
package urxb_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses on apb)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DATA   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CTL_B  = 8'h08;
   localparam logic [7:0] ADDR_FORMAT = 8'h0C;
   localparam logic [7:0] ADDR_BAUD   = 8'h10;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ST_COMPLETE   = 7;
   localparam int ST_FRAME_ERR  = 4;
   localparam int ST_OVERRUN    = 3;
   localparam int ST_PARITY_ERR = 2;
   localparam int CB_IRQ_EN     = 7;
   localparam int CB_RX_ON      = 4;
   localparam int CB_SZ2        = 2;
   localparam int CB_NINTH      = 1;
   localparam int FF_PEN   = 5;
   localparam int FF_PODD  = 4;
   localparam int FF_STOP2 = 3;
   localparam int FF_SZ1   = 2;
   localparam int FF_SZ0   = 1;
   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0]  CTL_B_RESET  = 8'h00;
   localparam logic [7:0]  FORMAT_RESET = 8'h06;
   localparam logic [15:0] BAUD_RESET   = 16'h0081;
   localparam logic [2:0]  SIZE_NINE    = 3'h7;
   localparam logic [3:0]  SAMPLE_MID   = 4'h7;
   localparam logic [3:0]  SAMPLE_LAST  = 4'hF;
   typedef enum logic [1:0] {
      URXB_IDLE  = 2'b00,
      URXB_START = 2'b01,
      URXB_BITS  = 2'b10,
      URXB_STOP  = 2'b11
   } urxb_state_t;
endpackage

// ===== core/urxb_top.sv
`timescale 1ns/1ps
module urxb_top
   import urxb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_rx_pin,
   input  wire logic        global_irq_enable,
   output logic             rx_irq,
   output logic             rx_pin_override
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  ctl_b, next_ctl_b;
   logic [7:0]  fmt, next_fmt;
   logic [15:0] baud, next_baud;
   logic [8:0]  fd [2];
   logic [2:0]  err_flags [2];   // {frame, overrun, parity}
   logic [8:0]  next_fd [2];
   logic [2:0]  next_err_flags [2];
   logic        rd_ptr, next_rd_ptr;
   logic [1:0]  count, next_count;
   logic        ovr_pend, next_ovr_pend;
   logic [1:0]  pin_s;
   urxb_state_t st, next_st;
   logic [15:0] bdiv, next_bdiv;
   logic [3:0]  smp, next_smp;
   logic [3:0]  bitn, next_bitn;
   logic [9:0]  shf, next_shf;
   logic        held, next_held;
   logic [9:0]  held_sh, next_held_sh;
   logic        held_frame_err, next_held_frame_err;
   logic [31:0] next_prdata;
   logic        next_irq;
   logic        rx_in, tick, rd_data, access, rx_on, stop_bit;
   logic [2:0]  shown_err;
   logic [3:0]  nbits;
   logic [2:0]  csize;

   function automatic logic [3:0] data_bits(input logic [2:0] s);
      if (s == SIZE_NINE) begin
         data_bits = 4'h9;
      end else begin
         data_bits = {2'b00, s[1:0]} + 4'h5;
      end
   endfunction

   function automatic logic [7:0] mask_low(input logic [8:0] d, input logic [2:0] s);
      logic [7:0] m;
      m = (s == SIZE_NINE || s[1:0] == 2'h3) ? 8'hFF : (8'hFF >> (3 - s[1:0]));
      mask_low = d[7:0] & m;
   endfunction

   assign csize  = {ctl_b[CB_SZ2], fmt[FF_SZ1], fmt[FF_SZ0]};
   assign nbits  = data_bits(csize) + {3'h0, fmt[FF_PEN]};
   assign rx_on  = ctl_b[CB_RX_ON];
   assign rx_in  = rx_on ? pin_s[1] : 1'b1;
   assign access = psel && penable;
   assign rd_data = access && !pwrite && paddr == ADDR_DATA;
   assign tick   = bdiv == 16'h0000;
   assign stop_bit = rx_in;
   // flags of an empty buffer read zero; parity flag reads zero while checking is off
   assign shown_err = (count != 2'h0) ? err_flags[rd_ptr] & {2'b11, fmt[FF_PEN]}
                                      : 3'h0;

   // ----------------------------------------------------------------
   // receiver front end
   // ----------------------------------------------------------------
   always_comb begin
      logic [8:0] dat;
      logic       par;
      logic [9:0] aligned;
      dat = 9'h000;
      par = 1'b0;
      aligned = 10'h000;
      next_st = st;
      next_bdiv = tick ? baud : bdiv - 16'h0001;
      next_smp = smp;
      next_bitn = bitn;
      next_shf = shf;
      next_held = held;
      next_held_sh = held_sh;
      next_held_frame_err = held_frame_err;
      next_ovr_pend = ovr_pend;
      next_fd = fd;
      next_err_flags = err_flags;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (rd_data && count != 2'h0) begin
         next_rd_ptr = ~rd_ptr;
         next_count = count - 2'h1;
      end
      if (held && next_count != 2'h2) begin
         // move waiting frame into the fifo; first data bit lands at bit 0,
         // the parity bit, if any, sits just above the data bits
         aligned = held_sh >> (4'hA - nbits);
         dat = 9'(aligned & ~(10'h3FF << data_bits(csize)));
         par = (^aligned) ^ fmt[FF_PODD];
         // write slot follows the read position after any pop in this cycle
         next_fd[next_rd_ptr ^ next_count[0]] = dat;
         next_err_flags[next_rd_ptr ^ next_count[0]] =
            {held_frame_err, ovr_pend, par & fmt[FF_PEN]};
         next_count = next_count + 2'h1;
         next_held = 1'b0;
         next_ovr_pend = 1'b0;
      end
      if (tick) begin
         next_smp = smp + 4'h1;
         case (st)
            URXB_IDLE: begin
               next_smp = 4'h0;
               if (!rx_in) begin
                  next_st = URXB_START;
                  // still full after this cycle's moves, with a frame waiting
                  if (next_held && next_count == 2'h2) begin
                     next_ovr_pend = 1'b1;
                  end
               end
            end
            URXB_START: begin
               if (smp == SAMPLE_MID) begin
                  next_st = rx_in ? URXB_IDLE : URXB_START;
               end else if (smp == SAMPLE_LAST) begin
                  next_st = URXB_BITS;
                  next_bitn = 4'h0;
               end
            end
            URXB_BITS: begin
               if (smp == SAMPLE_MID) begin
                  next_shf = {rx_in, shf[9:1]};
                  next_bitn = bitn + 4'h1;
               end else if (smp == SAMPLE_LAST && bitn == nbits) begin
                  next_st = URXB_STOP;
               end
            end
            URXB_STOP: begin
               if (smp == SAMPLE_MID) begin
                  // only the first stop bit matters
                  next_st = URXB_IDLE;
                  next_held = 1'b1;
                  next_held_sh = shf;
                  next_held_frame_err = !stop_bit;
               end
            end
            default: next_st = URXB_IDLE;
         endcase
      end
      if (!rx_on) begin
         next_st = URXB_IDLE;
         next_held = 1'b0;
         next_count = 2'h0;
         next_ovr_pend = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registers and apb
   // ----------------------------------------------------------------
   always_comb begin
      next_ctl_b = ctl_b;
      next_fmt = fmt;
      next_baud = baud;
      next_prdata = prdata;
      if (access && pwrite) begin
         if (paddr == ADDR_CTL_B) begin
            next_ctl_b = pwdata[7:0] & ~(8'h01 << CB_NINTH);
         end else if (paddr == ADDR_FORMAT) begin
            next_fmt = pwdata[7:0];
         end else if (paddr == ADDR_BAUD) begin
            next_baud = pwdata[15:0];
         end
         // status writes leave the error flags untouched
      end
      if (psel && !penable && !pwrite) begin
         if (paddr == ADDR_DATA) begin
            next_prdata = {24'h0, mask_low(fd[rd_ptr], csize)};
         end else if (paddr == ADDR_STATUS) begin
            next_prdata = {24'h0, count != 2'h0, 2'b00, shown_err, 2'b00};
         end else if (paddr == ADDR_CTL_B) begin
            next_prdata = {24'h0, ctl_b | ({7'h0, fd[rd_ptr][8]} << CB_NINTH)};
         end else if (paddr == ADDR_FORMAT) begin
            next_prdata = {24'h0, fmt};
         end else if (paddr == ADDR_BAUD) begin
            next_prdata = {16'h0, baud};
         end else begin
            next_prdata = 32'h0;
         end
      end
      next_irq = ctl_b[CB_IRQ_EN] && (next_count != 2'h0) && global_irq_enable;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctl_b <= CTL_B_RESET;
         fmt <= FORMAT_RESET;
         baud <= BAUD_RESET;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         rx_irq <= 1'b0;
         rx_pin_override <= 1'b0;
         pin_s <= 2'b11;
         st <= URXB_IDLE;
         bdiv <= 16'h0;
         smp <= 4'h0;
         bitn <= 4'h0;
         shf <= 10'h0;
         held <= 1'b0;
         held_sh <= 10'h0;
         held_frame_err <= 1'b0;
         ovr_pend <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         fd <= '{default: 9'h0};
         err_flags <= '{default: 3'h0};
      end else begin
         ctl_b <= next_ctl_b;
         fmt <= next_fmt;
         baud <= next_baud;
         prdata <= next_prdata;
         pready <= psel && !penable;
         pslverr <= 1'b0;
         rx_irq <= next_irq;
         rx_pin_override <= next_ctl_b[CB_RX_ON];
         pin_s <= {pin_s[0], serial_rx_pin};
         st <= next_st;
         bdiv <= next_bdiv;
         smp <= next_smp;
         bitn <= next_bitn;
         shf <= next_shf;
         held <= next_held;
         held_sh <= next_held_sh;
         held_frame_err <= next_held_frame_err;
         ovr_pend <= next_ovr_pend;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         fd <= next_fd;
         err_flags <= next_err_flags;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   flush_on_disable_a: assert property (@(posedge clk) disable iff (reset)
      !ctl_b[CB_RX_ON] |=> count == 2'h0) else $error("buffer not flushed");
   read_advances_a: assert property (@(posedge clk) disable iff (reset)
      rd_data && count != 2'h0 && rx_on |=> rd_ptr != $past(rd_ptr))
      else $error("read did not advance");
   irq_follows_a: assert property (@(posedge clk) disable iff (reset)
      $past(ctl_b[CB_IRQ_EN] && global_irq_enable) && count != 2'h0
      |-> rx_irq)
      else $error("irq missing");
   no_err_irq_a: assert property (@(posedge clk) disable iff (reset)
      count == 2'h0 |-> !rx_irq) else $error("irq without data");
   parity_off_a: assert property (@(posedge clk) disable iff (reset)
      psel && !penable && !pwrite && paddr == ADDR_STATUS && !fmt[FF_PEN]
      |=> !prdata[ST_PARITY_ERR])
      else $error("parity flag shown while checking is off");
   abandon_a: assert property (@(posedge clk) disable iff (reset)
      !rx_on |=> st == URXB_IDLE && !held) else $error("frame kept");
   overrun_clr_a: assert property (@(posedge clk) disable iff (reset)
      held && !next_held && rx_on |=> !ovr_pend) else $error("overrun kept");
   fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
      count <= 2'h2) else $error("fifo overflow");
   pin_release_a: assert property (@(posedge clk) disable iff (reset)
      rx_pin_override == rx_on) else $error("pin ownership wrong");
   fill_c: cover property (@(posedge clk) disable iff (reset) count == 2'h2);
   ovr_c: cover property (@(posedge clk) disable iff (reset) ovr_pend);
   irq_c: cover property (@(posedge clk) disable iff (reset) rx_irq);
endmodule

// ===== bench/urxb_serial_tx.sv
`timescale 1ns/1ps
// ------------------------------
// remote serial transmitter
// ------------------------------
module urxb_serial_tx #(
   parameter int BIT_CLOCKS = 16
) (
   input  wire logic clk,
   output logic      line
);
   initial line = 1'b1;
   task automatic put(input logic b);
      line <= b;
      repeat (BIT_CLOCKS) @(posedge clk);
   endtask
   // start, n data bits lsb first, parity when par >= 0, stops[0] first
   task automatic send(input logic [8:0] d, input int n, input int par,
                       input logic [1:0] stops);
      @(posedge clk);
      put(1'b0);
      for (int i = 0; i < n; i++) put(d[i]);
      if (par >= 0) put(par[0]);
      put(stops[0]);
      put(stops[1]);
      line <= 1'b1;
   endtask
endmodule

// ===== bench/uart_receive_buffer_status_test.sv
`timescale 1ns/1ps
module uart_receive_buffer_status_test import urxb_pkg::*;;
   // ------------------------------
   // stimulus and checks
   // ------------------------------
   localparam logic [31:0] SM = 32'h0000009C;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gie = 1'b1;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, acc;
   logic        pready, pslverr, rx_pin, rx_irq, ovr;
   int          mismatches = 0, comparisons = 0, cycles = 0;
   int          n = 0;

   initial forever #25 clk = ~clk;

   urxb_top i_dut (
      .clk               (clk),
      .reset             (reset),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .paddr             (paddr),
      .pwdata            (pwdata),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .serial_rx_pin     (rx_pin),
      .global_irq_enable (gie),
      .rx_irq            (rx_irq),
      .rx_pin_override   (ovr)
   );
   // bit period is 16 clocks with the baud register at zero
   urxb_serial_tx #(.BIT_CLOCKS(16)) i_tx (
      .clk  (clk),
      .line (rx_pin)
   );

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(n, e, rd & m);
   endtask

   task automatic rx(input logic [8:0] d, input int n, input int par, input logic [1:0] s);
      i_tx.send(d, n, par, s);
      repeat (4) @(posedge clk);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rdchk("ctl_b reset", ADDR_CTL_B, 32'hFF, {24'h0, CTL_B_RESET});
      rdchk("format reset", ADDR_FORMAT, 32'hFF, {24'h0, FORMAT_RESET});
      rdchk("baud reset", ADDR_BAUD, 32'hFFFF, {16'h0, BAUD_RESET});
      rdchk("unmapped", 8'h14, 32'hFFFFFFFF, 32'h0);
      apb(1'b1, ADDR_BAUD, 32'h0);
      // the divider first runs out the reset reload before the new rate applies
      repeat (140) @(posedge clk);
      apb(1'b1, ADDR_CTL_B, 32'h90);
      check("pin override", 32'h1, {31'h0, ovr});
      rx(9'h0A5, 8, -1, 2'b11);
      rdchk("status full", ADDR_STATUS, SM, 32'h80);
      check("irq set", 32'h1, {31'h0, rx_irq});
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      check("irq gated", 32'h0, {31'h0, rx_irq});
      gie <= 1'b1;
      rdchk("data", ADDR_DATA, 32'hFF, 32'hA5);
      rdchk("status empty", ADDR_STATUS, SM, 32'h0);
      check("irq clear", 32'h0, {31'h0, rx_irq});
      // two buffered frames, the first with a bad stop bit
      apb(1'b1, ADDR_CTL_B, 32'h10);
      apb(1'b1, ADDR_FORMAT, 32'h0E);
      rx(9'h03C, 8, -1, 2'b10);
      rx(9'h0C3, 8, -1, 2'b11);
      check("no error irq", 32'h0, {31'h0, rx_irq});
      rdchk("fe first", ADDR_STATUS, SM, 32'h90);
      apb(1'b1, ADDR_STATUS, 32'h0);
      rdchk("fe kept", ADDR_STATUS, SM, 32'h90);
      rdchk("data first", ADDR_DATA, 32'hFF, 32'h3C);
      rdchk("fe next", ADDR_STATUS, SM, 32'h80);
      rdchk("data next", ADDR_DATA, 32'hFF, 32'hC3);
      apb(1'b1, ADDR_CTL_B, 32'h90);
      // even then odd parity, good then bad parity bit
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_FORMAT, i[1] ? 32'h36 : 32'h26);
         rx(9'h05B, 8, int'((^8'h5B) ^ i[1] ^ i[0]), 2'b11);
         rdchk("parity status", ADDR_STATUS, SM, i[0] ? 32'h84 : 32'h80);
         rdchk("parity data", ADDR_DATA, 32'hFF, 32'h5B);
      end
      apb(1'b1, ADDR_FORMAT, 32'h06);
      rx(9'h05A, 8, -1, 2'b11);
      rdchk("parity off", ADDR_STATUS, SM, 32'h80);
      apb(1'b0, ADDR_DATA, 32'h0);
      apb(1'b1, ADDR_CTL_B, 32'h94);
      rx(9'h1A5, 9, -1, 2'b11);
      rdchk("ninth bit", ADDR_CTL_B, 32'h02, 32'h02);
      rdchk("nine data", ADDR_DATA, 32'hFF, 32'hA5);
      apb(1'b1, ADDR_CTL_B, 32'h90);
      apb(1'b1, ADDR_FORMAT, 32'h00);
      rx(9'h0FF, 5, -1, 2'b11);
      rdchk("short data", ADDR_DATA, 32'hFF, 32'h1F);
      // four frames unread: buffer full, third waiting, fourth overwrites the third
      apb(1'b1, ADDR_FORMAT, 32'h06);
      for (int i = 1; i < 5; i++) rx(9'(17 * i), 8, -1, 2'b11);
      acc = 32'h0;
      for (int i = 0; i < 4; i++) begin
         if (i == 3) rx(9'h055, 8, -1, 2'b11);
         apb(1'b0, ADDR_STATUS, 32'h0);
         acc = acc | rd;
         apb(1'b0, ADDR_DATA, 32'h0);
      end
      check("overrun seen", 32'h08, acc & 32'h08);
      rx(9'h066, 8, -1, 2'b11);
      rdchk("overrun cleared", ADDR_STATUS, SM, 32'h80);
      // two frames buffered, emptied by reading data until the flag drops
      rx(9'h077, 8, -1, 2'b11);
      apb(1'b0, ADDR_STATUS, 32'h0);
      while (rd[ST_COMPLETE] === 1'b1 && n < 4) begin
         apb(1'b0, ADDR_DATA, 32'h0);
         n++;
         apb(1'b0, ADDR_STATUS, 32'h0);
      end
      check("flush reads", 32'h2, 32'(n));
      rx(9'h088, 8, -1, 2'b11);
      // one frame buffered, disable in the middle of the next
      fork
         i_tx.send(9'h0F0, 8, -1, 2'b11);
         begin
            repeat (60) @(posedge clk);
            apb(1'b1, ADDR_CTL_B, 32'h00);
         end
      join
      check("pin released", 32'h0, {31'h0, ovr});
      rdchk("flushed", ADDR_STATUS, SM, 32'h0);
      check("irq flushed", 32'h0, {31'h0, rx_irq});
      apb(1'b1, ADDR_CTL_B, 32'h90);
      repeat (40) @(posedge clk);
      rdchk("abandoned", ADDR_STATUS, SM, 32'h0);
      tally_and_finish();
   end
endmodule
